// file: umcls_pkg.sv
// Constants shared by the modem control and line status block.
package umcls_pkg;

  // Register byte addresses.
  localparam logic [9:0] MODEM_LINE_CONTROL_ADDR = 10'h3FC;
  localparam logic [9:0] SERIAL_LINE_STATE_ADDR  = 10'h3FD;

  // Modem control field positions.
  localparam int unsigned MLC_TERM_READY_BIT = 0;
  localparam int unsigned MLC_SEND_REQ_BIT   = 1;
  localparam int unsigned MLC_IRQ_ENABLE_BIT = 3;
  localparam int unsigned MLC_LOOPBACK_BIT   = 4;

  // Writable modem control bits; bits 2 and 5 to 7 stay zero.
  localparam logic [7:0] MLC_WRITE_MASK = 8'h1B;
  localparam logic [7:0] MLC_RESET      = 8'h00;

  // Line status field positions.
  localparam int unsigned SLS_CHAR_AVAIL_BIT = 0;
  localparam int unsigned SLS_OVERRUN_BIT    = 1;
  localparam int unsigned SLS_PARITY_BIT     = 2;
  localparam int unsigned SLS_FRAMING_BIT    = 3;
  localparam int unsigned SLS_BREAK_BIT      = 4;
  localparam int unsigned SLS_HOLD_EMPTY_BIT = 5;
  localparam int unsigned SLS_ALL_IDLE_BIT   = 6;
  localparam logic [7:0]  SLS_RESET          = 8'h60;

  // Line control field positions used here.
  localparam int unsigned LCR_PARITY_EN_BIT  = 3;
  localparam int unsigned LCR_EVEN_BIT       = 4;
  localparam int unsigned LCR_STICK_BIT      = 5;
  localparam int unsigned LCR_SET_BREAK_BIT  = 6;

  // Interrupt enable field positions.
  localparam int unsigned IER_HOLD_EMPTY_BIT = 1;
  localparam int unsigned IER_LINE_STAT_BIT  = 2;

  // Frame length piece, in bit times, and the value read from unmapped addresses.
  localparam logic [3:0] FRAME_FIXED_BITS = 4'h7;
  localparam logic [7:0] READ_IDLE_VALUE  = 8'h00;

  // Break detector states.
  typedef enum logic [1:0] {
    BRK_IDLE,
    BRK_COUNT,
    BRK_HELD
  } umcls_brk_state_type;

endpackage

// file: umcls_parity.sv
// Parity check of a received character.
`timescale 1ns/1ns
module umcls_parity
  import umcls_pkg::*;
(
  // Received character
  input  wire logic [7:0] data_i,
  input  wire logic [1:0] word_len_sel_i,
  input  wire logic       parity_bit_i,
  // Line format
  input  wire logic       enable_i,
  input  wire logic       even_i,
  input  wire logic       stick_i,
  // Result
  output logic            fault_o
);

  logic [7:0] used_bits;
  logic       expected;

  // Bits above the word length are not part of the character.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_mask
      if (g < 5) begin : g_low
        assign used_bits[g] = data_i[g];
      end else begin : g_high
        assign used_bits[g] = data_i[g] & (word_len_sel_i >= 2'(g - 4));
      end
    end
  endgenerate

  // Stick parity forces the bit opposite to the even select.
  always_comb begin
    if (stick_i) begin
      expected = ~even_i;
    end else begin
      expected = even_i ? (^used_bits) : ~(^used_bits);
    end
    fault_o = enable_i & (parity_bit_i != expected); // RULE_20 RULE_14
  end

endmodule // umcls_parity

// file: umcls_top.sv
// Modem control and line status block of a serial port.
`timescale 1ns/1ns
// What this block does
// RULE_01 - Control bit 0 set drives terminal ready low
// RULE_02 - Control bit 1 set drives send request low
// RULE_03 - Interrupt line passes only with control bit 3
// RULE_04 - Loopback holds serial output marking, ignores input
// RULE_05 - Loopback routes transmit shifter into receiver
// RULE_06 - Loopback feeds control outputs into modem inputs
// RULE_07 - Loopback forces modem control pins high
// RULE_08 - Status bit 7 zero; bits 0-6 fixed order
// RULE_09 - Error bits raise line interrupt when enabled
// RULE_10 - Status read clears error bits 1-4
// RULE_11 - Error flags set at stop bit
// RULE_12 - Data ready follows buffered received data
// RULE_13 - Overrun set when unread character overwritten
// RULE_14 - Parity error on parity mismatch
// RULE_15 - Framing error when stop bit is spacing
// RULE_16 - Break when spacing exceeds a character time
// RULE_17 - Holding empty set on transfer, cleared by write
// RULE_18 - Holding empty interrupt, cleared by ident read
// RULE_19 - Transmitter empty while holding and shifter empty
// RULE_20 - Parity uses even select and enable bits
// RULE_21 - Unused control bits read zero, ignore writes
module umcls_top
  import umcls_pkg::*;
#(
  parameter int unsigned ADDR_W = 10
)
(
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  // Host register port
  input  wire logic [ADDR_W-1:0] host_addr_i,
  input  wire logic              host_rd_i,
  input  wire logic              host_wr_i,
  input  wire logic [7:0]        host_wdata_i,
  output logic      [7:0]        host_rdata_o,
  // Settings held by neighbouring registers
  input  wire logic [7:0]        line_control_i,
  input  wire logic [7:0]        irq_enable_i,
  input  wire logic              irq_ident_read_i,
  input  wire logic              irq_other_i,
  input  wire logic              irq_route_b_i,
  // Receiver handshakes
  input  wire logic              bit_tick_i,
  input  wire logic              rx_char_done_i,
  input  wire logic [7:0]        rx_data_i,
  input  wire logic              rx_parity_in_i,
  input  wire logic              rx_stop_in_i,
  input  wire logic              rx_buffer_drained_i,
  output logic                   rx_serial_o,
  // Transmitter handshakes
  input  wire logic              tx_hold_write_i,
  input  wire logic              tx_shift_load_i,
  input  wire logic              tx_shift_done_i,
  input  wire logic              tx_shift_out_i,
  // Serial and modem pins
  input  wire logic              serial_rx_pin_i,
  output logic                   serial_tx_pin_o,
  output logic                   terminal_ready_out_n_o,
  output logic                   send_request_out_n_o,
  input  wire logic [3:0]        modem_pin_n_i,
  output logic      [3:0]        modem_in_n_o,
  // Interrupt paths
  output logic                   line_stat_irq_o,
  output logic                   hold_empty_irq_o,
  output logic                   serial_irq_line_a_o,
  output logic                   serial_irq_line_b_o
);

  logic [7:0]          modem_line_control_reg;
  logic                rx_char_available_reg;
  logic                rx_overrun_reg;
  logic                rx_parity_fault_reg;
  logic                rx_framing_fault_reg;
  logic                rx_break_seen_reg;
  logic                tx_hold_empty_reg;
  logic                tx_shift_busy_reg;
  logic                hold_irq_pending_reg;
  logic [7:0]          rdata_reg;
  umcls_brk_state_type brk_state_reg;
  logic [3:0]          brk_count_reg;

  logic                loopback;
  logic                tx_all_idle;
  logic [7:0]          serial_line_state;
  logic                parity_fault;
  logic                mlc_write;
  logic                sls_read;
  logic                status_clear;
  logic                break_set;
  logic [3:0]          frame_bits;
  logic                any_irq;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] target);
    addr_hit = (addr == ADDR_W'(target));
  endfunction

  assign mlc_write    = host_wr_i & addr_hit(host_addr_i, MODEM_LINE_CONTROL_ADDR);
  assign sls_read     = host_rd_i & addr_hit(host_addr_i, SERIAL_LINE_STATE_ADDR);
  assign status_clear = sls_read;
  assign loopback     = modem_line_control_reg[MLC_LOOPBACK_BIT];

  // Only the defined bits are stored, so the rest always read back as zero.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      modem_line_control_reg <= MLC_RESET;
    end else if (mlc_write) begin
      modem_line_control_reg <= host_wdata_i & MLC_WRITE_MASK; // RULE_21
    end
  end

  // Modem control pins go inactive in loopback so the far end sees no handshake.
  always_comb begin
    terminal_ready_out_n_o = loopback | ~modem_line_control_reg[MLC_TERM_READY_BIT]; // RULE_01 RULE_07
    send_request_out_n_o   = loopback | ~modem_line_control_reg[MLC_SEND_REQ_BIT];   // RULE_02 RULE_07
  end

  // Ring has no control bit to feed it, so it reads inactive in loopback.
  always_comb begin
    if (loopback) begin
      modem_in_n_o[0] = ~modem_line_control_reg[MLC_SEND_REQ_BIT];   // RULE_06
      modem_in_n_o[1] = ~modem_line_control_reg[MLC_TERM_READY_BIT]; // RULE_06
      modem_in_n_o[2] = 1'b1;
      modem_in_n_o[3] = ~modem_line_control_reg[MLC_IRQ_ENABLE_BIT]; // RULE_06
    end else begin
      modem_in_n_o = modem_pin_n_i;
    end
  end

  // Serial paths; the break control acts on the pin only outside loopback.
  always_comb begin
    rx_serial_o     = loopback ? tx_shift_out_i : serial_rx_pin_i; // RULE_04 RULE_05
    serial_tx_pin_o = loopback | (tx_shift_out_i & ~line_control_i[LCR_SET_BREAK_BIT]); // RULE_04
  end

  umcls_parity u_parity (
    .data_i         (rx_data_i),
    .word_len_sel_i (line_control_i[1:0]),
    .parity_bit_i   (rx_parity_in_i),
    .enable_i       (line_control_i[LCR_PARITY_EN_BIT]),
    .even_i         (line_control_i[LCR_EVEN_BIT]),
    .stick_i        (line_control_i[LCR_STICK_BIT]),
    .fault_o        (parity_fault)
  );

  // A new character wins over a drain in the same cycle, so none is lost.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_char_available_reg <= 1'b0;
    end else if (rx_char_done_i) begin
      rx_char_available_reg <= 1'b1; // RULE_12
    end else if (rx_buffer_drained_i) begin
      rx_char_available_reg <= 1'b0; // RULE_12
    end
  end

  // Error flags latch at the stop bit; a fresh error beats a clearing read.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_overrun_reg       <= 1'b0;
      rx_parity_fault_reg  <= 1'b0;
      rx_framing_fault_reg <= 1'b0;
    end else begin
      if (rx_char_done_i && rx_char_available_reg && !rx_buffer_drained_i) begin
        rx_overrun_reg <= 1'b1; // RULE_13 RULE_11
      end else if (status_clear) begin
        rx_overrun_reg <= 1'b0; // RULE_10
      end
      if (rx_char_done_i && parity_fault) begin
        rx_parity_fault_reg <= 1'b1; // RULE_14 RULE_11
      end else if (status_clear) begin
        rx_parity_fault_reg <= 1'b0; // RULE_10
      end
      if (rx_char_done_i && !rx_stop_in_i) begin
        rx_framing_fault_reg <= 1'b1; // RULE_15 RULE_11
      end else if (status_clear) begin
        rx_framing_fault_reg <= 1'b0; // RULE_10
      end
    end
  end

  // Start, data, parity and stop bits make one character time.
  assign frame_bits = FRAME_FIXED_BITS + {2'b00, line_control_i[1:0]}
                      + {3'b000, line_control_i[LCR_PARITY_EN_BIT]};
  assign break_set  = (brk_state_reg == BRK_COUNT) && bit_tick_i && !rx_serial_o
                      && (brk_count_reg == frame_bits);

  // One break is reported per spacing period; the line must mark before the next.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      brk_state_reg <= BRK_IDLE;
      brk_count_reg <= 4'h0;
    end else begin
      case (brk_state_reg)
        BRK_IDLE: begin
          brk_count_reg <= 4'h0;
          if (!rx_serial_o) begin
            brk_state_reg <= BRK_COUNT;
          end
        end
        BRK_COUNT: begin
          if (rx_serial_o) begin
            brk_state_reg <= BRK_IDLE;
          end else if (break_set) begin
            brk_state_reg <= BRK_HELD; // RULE_16
          end else if (bit_tick_i) begin
            brk_count_reg <= brk_count_reg + 4'h1;
          end
        end
        BRK_HELD: begin
          if (rx_serial_o) begin
            brk_state_reg <= BRK_IDLE;
          end
        end
        default: begin
          brk_state_reg <= BRK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_break_seen_reg <= 1'b0;
    end else if (break_set) begin
      rx_break_seen_reg <= 1'b1; // RULE_16
    end else if (status_clear) begin
      rx_break_seen_reg <= 1'b0; // RULE_10
    end
  end

  // Transfer into the shifter wins over a host write in the same cycle.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tx_hold_empty_reg <= 1'b1;
    end else if (tx_shift_load_i) begin
      tx_hold_empty_reg <= 1'b1; // RULE_17
    end else if (tx_hold_write_i) begin
      tx_hold_empty_reg <= 1'b0; // RULE_17
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tx_shift_busy_reg <= 1'b0;
    end else if (tx_shift_load_i) begin
      tx_shift_busy_reg <= 1'b1; // RULE_19
    end else if (tx_shift_done_i) begin
      tx_shift_busy_reg <= 1'b0; // RULE_19
    end
  end

  assign tx_all_idle = tx_hold_empty_reg & ~tx_shift_busy_reg; // RULE_19

  // The holding-empty request is acknowledged by an identification read.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      hold_irq_pending_reg <= 1'b1;
    end else if (tx_shift_load_i) begin
      hold_irq_pending_reg <= 1'b1; // RULE_18
    end else if (irq_ident_read_i || tx_hold_write_i) begin
      hold_irq_pending_reg <= 1'b0; // RULE_18
    end
  end

  assign serial_line_state = {1'b0, tx_all_idle, tx_hold_empty_reg, rx_break_seen_reg,
                              rx_framing_fault_reg, rx_parity_fault_reg, rx_overrun_reg,
                              rx_char_available_reg}; // RULE_08

  always_comb begin
    line_stat_irq_o  = irq_enable_i[IER_LINE_STAT_BIT] & (|serial_line_state[4:1]); // RULE_09
    hold_empty_irq_o = irq_enable_i[IER_HOLD_EMPTY_BIT] & tx_hold_empty_reg & hold_irq_pending_reg; // RULE_18
    any_irq          = line_stat_irq_o | hold_empty_irq_o | irq_other_i;
    serial_irq_line_a_o = modem_line_control_reg[MLC_IRQ_ENABLE_BIT] & any_irq & ~irq_route_b_i; // RULE_03
    serial_irq_line_b_o = modem_line_control_reg[MLC_IRQ_ENABLE_BIT] & any_irq & irq_route_b_i;  // RULE_03
  end

  // Read data shows the value before the read's own clearing takes effect.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_reg <= READ_IDLE_VALUE;
    end else if (host_rd_i) begin
      if (addr_hit(host_addr_i, MODEM_LINE_CONTROL_ADDR)) begin
        rdata_reg <= modem_line_control_reg;
      end else if (sls_read) begin
        rdata_reg <= serial_line_state; // RULE_08
      end else begin
        rdata_reg <= READ_IDLE_VALUE;
      end
    end
  end

  assign host_rdata_o = rdata_reg;

  property p_term_ready;
    @(posedge clock_i) disable iff (sys_rst_i)
      mlc_write && !host_wdata_i[MLC_LOOPBACK_BIT] |=> terminal_ready_out_n_o == !$past(host_wdata_i[0]);
  endproperty
  a_term_ready: assert property (p_term_ready) else $error("terminal ready pin wrong"); // RULE_01

  property p_send_req;
    @(posedge clock_i) disable iff (sys_rst_i)
      mlc_write && !host_wdata_i[MLC_LOOPBACK_BIT] |=> send_request_out_n_o == !$past(host_wdata_i[1]);
  endproperty
  a_send_req: assert property (p_send_req) else $error("send request pin wrong"); // RULE_02

  property p_irq_gate;
    @(posedge clock_i) disable iff (sys_rst_i)
      mlc_write && !host_wdata_i[MLC_IRQ_ENABLE_BIT] |=> !serial_irq_line_a_o && !serial_irq_line_b_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt passed while gated"); // RULE_03

  property p_loop_paths;
    @(posedge clock_i) disable iff (sys_rst_i)
      loopback |-> serial_tx_pin_o && (rx_serial_o == tx_shift_out_i)
                   && terminal_ready_out_n_o && send_request_out_n_o
                   && (modem_in_n_o[0] == !modem_line_control_reg[MLC_SEND_REQ_BIT]);
  endproperty
  a_loop_paths: assert property (p_loop_paths) else $error("loopback routing wrong"); // RULE_04 RULE_05 RULE_06 RULE_07

  property p_ctl_readback;
    @(posedge clock_i) disable iff (sys_rst_i)
      mlc_write ##1 !mlc_write ##1 (host_rd_i && addr_hit(host_addr_i, MODEM_LINE_CONTROL_ADDR))
        |=> host_rdata_o == ($past(host_wdata_i, 3) & MLC_WRITE_MASK);
  endproperty
  a_ctl_readback: assert property (p_ctl_readback) else $error("control readback wrong"); // RULE_21

  property p_status_read;
    @(posedge clock_i) disable iff (sys_rst_i)
      sls_read && !rx_char_done_i && !break_set |=> serial_line_state[4:1] == 4'h0 && !host_rdata_o[7];
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read did not clear"); // RULE_10 RULE_08

  property p_framing;
    @(posedge clock_i) disable iff (sys_rst_i)
      rx_char_done_i && !rx_stop_in_i |=> rx_framing_fault_reg && rx_char_available_reg;
  endproperty
  a_framing: assert property (p_framing) else $error("framing error missed"); // RULE_15 RULE_12

  property p_overrun;
    @(posedge clock_i) disable iff (sys_rst_i)
      rx_char_done_i && rx_char_available_reg && !rx_buffer_drained_i |=> rx_overrun_reg;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed"); // RULE_13

  property p_line_irq;
    @(posedge clock_i) disable iff (sys_rst_i)
      rx_char_done_i && !rx_stop_in_i && irq_enable_i[IER_LINE_STAT_BIT] ##1 irq_enable_i[IER_LINE_STAT_BIT]
        |-> line_stat_irq_o;
  endproperty
  a_line_irq: assert property (p_line_irq) else $error("line status interrupt missing"); // RULE_09

  property p_hold_write;
    @(posedge clock_i) disable iff (sys_rst_i)
      tx_hold_write_i && !tx_shift_load_i |=> !tx_hold_empty_reg && !serial_line_state[SLS_ALL_IDLE_BIT];
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("holding write did not clear"); // RULE_17 RULE_19

  property p_hold_irq_ack;
    @(posedge clock_i) disable iff (sys_rst_i)
      irq_ident_read_i && !tx_shift_load_i ##1 !tx_shift_load_i [*2] |-> !hold_empty_irq_o;
  endproperty
  a_hold_irq_ack: assert property (p_hold_irq_ack) else $error("holding interrupt not cleared"); // RULE_18

  property p_break;
    @(posedge clock_i) disable iff (sys_rst_i)
      break_set |=> rx_break_seen_reg && (brk_state_reg == BRK_HELD);
  endproperty
  a_break: assert property (p_break) else $error("break not flagged"); // RULE_16

  c_loopback: cover property (@(posedge clock_i) disable iff (sys_rst_i) loopback && rx_char_done_i);
  c_break:    cover property (@(posedge clock_i) disable iff (sys_rst_i) break_set);
  c_overrun:  cover property (@(posedge clock_i) disable iff (sys_rst_i) rx_char_done_i && rx_char_available_reg);
  c_hold_irq: cover property (@(posedge clock_i) disable iff (sys_rst_i) hold_empty_irq_o ##1 irq_ident_read_i);

endmodule // umcls_top

// file: umcls_modem_model.sv
// External modem model that answers on the modem control and serial pins.
`timescale 1ns/1ns
module umcls_modem_model #(
  parameter int unsigned DLY = 2
)
(
  // Clock
  input  wire logic       clock_i,
  // Control pins from the port
  input  wire logic       terminal_ready_out_n_i,
  input  wire logic       send_request_out_n_i,
  // Line behaviour chosen by the bench
  input  wire logic       line_level_i,
  input  wire logic       ring_i,
  // Pins into the port
  output logic            serial_rx_pin_o,
  output logic [3:0]      modem_pin_n_o
);
  logic [7:0] cts_pipe_reg;

  // A real modem grants clear to send only some cycles after the request.
  always_ff @(posedge clock_i) begin
    cts_pipe_reg <= {cts_pipe_reg[6:0], send_request_out_n_i};
  end

  assign serial_rx_pin_o = line_level_i;
  assign modem_pin_n_o   = {terminal_ready_out_n_i, ~ring_i, terminal_ready_out_n_i, cts_pipe_reg[DLY]};
endmodule // umcls_modem_model

// file: tb_uart_modem_ctrl_line_status.sv
// Self-checking bench for the modem control and line status block.
`timescale 1ns/1ns
module tb_uart_modem_ctrl_line_status;
  import umcls_pkg::*;
  localparam int P_IDENT = 0, P_TICK = 1, P_DONE = 2, P_DRAIN = 3, P_HWR = 4, P_LOAD = 5, P_SDONE = 6;
  logic        clock_i   = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [9:0]  addr      = 10'h000;
  logic        rd = 1'b0, wr = 1'b0, probe = 1'b0, rd_taken = 1'b0;
  logic [7:0]  wdata = 8'h00, lcr = 8'h03, ier = 8'h00, rxd = 8'h00, rdata;
  logic [6:0]  pl = 7'h00;
  logic        other = 1'b0, route_b = 1'b0, par = 1'b0, stop = 1'b1, sout = 1'b1, line = 1'b1, ring = 1'b0;
  logic        rx_pin, rx_ser, tx_pin, dtr_n, rts_n, lsi, hei, irq_a, irq_b;
  logic [3:0]  mpin_n, min_n;
  logic [7:0]  mlc_m = 8'h00, sls_m = SLS_RESET;
  logic        pend_m = 1'b1;
  logic [11:0] exp_q[$];
  int          fail_count = 0, check_count = 0;

  always #5 clock_i = ~clock_i;

  umcls_top #(.ADDR_W(10)) umcls_top_inst (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .host_addr_i(addr), .host_rd_i(rd), .host_wr_i(wr),
    .host_wdata_i(wdata), .host_rdata_o(rdata), .line_control_i(lcr), .irq_enable_i(ier),
    .irq_ident_read_i(pl[P_IDENT]), .irq_other_i(other), .irq_route_b_i(route_b), .bit_tick_i(pl[P_TICK]),
    .rx_char_done_i(pl[P_DONE]), .rx_data_i(rxd), .rx_parity_in_i(par), .rx_stop_in_i(stop),
    .rx_buffer_drained_i(pl[P_DRAIN]), .rx_serial_o(rx_ser), .tx_hold_write_i(pl[P_HWR]),
    .tx_shift_load_i(pl[P_LOAD]), .tx_shift_done_i(pl[P_SDONE]), .tx_shift_out_i(sout),
    .serial_rx_pin_i(rx_pin), .serial_tx_pin_o(tx_pin), .terminal_ready_out_n_o(dtr_n),
    .send_request_out_n_o(rts_n), .modem_pin_n_i(mpin_n), .modem_in_n_o(min_n),
    .line_stat_irq_o(lsi), .hold_empty_irq_o(hei), .serial_irq_line_a_o(irq_a), .serial_irq_line_b_o(irq_b));

  umcls_modem_model #(.DLY(2)) umcls_modem_model_inst (
    .clock_i(clock_i), .terminal_ready_out_n_i(dtr_n), .send_request_out_n_i(rts_n),
    .line_level_i(line), .ring_i(ring), .serial_rx_pin_o(rx_pin), .modem_pin_n_o(mpin_n));

  task automatic cmp(input logic [11:0] got);
    logic [11:0] e;
    e = exp_q.pop_front();
    check_count++;
    if (got !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  // Read data is registered, so it is judged half a cycle after the taking edge.
  always @(posedge clock_i) rd_taken <= rd;
  always @(negedge clock_i) begin
    if (rd_taken) cmp({4'h0, rdata});
    if (probe) cmp({min_n, irq_b, irq_a, lsi, hei, rx_ser, tx_pin, rts_n, dtr_n});
  end

  task automatic step;
    @(posedge clock_i);
    #1;
  endtask

  task automatic pulse(input int i);
    step;
    pl[i] = 1'b1;
    step;
    pl[i] = 1'b0;
  endtask

  task automatic wreg(input logic [9:0] a, input logic [7:0] d);
    step;
    addr = a;
    wdata = d;
    wr = 1'b1;
    step;
    wr = 1'b0;
  endtask

  task automatic rreg(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back({4'h0, e});
    step;
    addr = a;
    rd = 1'b1;
    step;
    rd = 1'b0;
  endtask

  task automatic probe_pins;
    logic lp, li, hi, any;
    logic [3:0] mi;
    step;
    lp = mlc_m[4];
    li = ier[2] & |sls_m[4:1];
    hi = ier[1] & sls_m[5] & pend_m;
    any = mlc_m[3] & (li | hi | other);
    mi = lp ? {~mlc_m[3], 1'b1, ~mlc_m[0], ~mlc_m[1]} : mpin_n;
    exp_q.push_back({mi, any & route_b, any & ~route_b, li, hi, lp ? sout : line,
                     lp | (~lcr[6] & sout), lp | ~mlc_m[1], lp | ~mlc_m[0]});
    probe = 1'b1;
    step;
    probe = 1'b0;
  endtask

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clock_i);
    fail_count++;
    conclude;
  end

  initial begin
    logic [7:0] r;
    logic pexp;
    void'($urandom(32'h971C));
    repeat (20) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    rreg(MODEM_LINE_CONTROL_ADDR, MLC_RESET);
    rreg(SERIAL_LINE_STATE_ADDR, SLS_RESET);
    rreg(10'h3FE, READ_IDLE_VALUE);
    ier = 8'h06;
    // Half the writes select loopback, so both pin paths see random traffic.
    for (int i = 0; i < 12; i++) begin
      r = 8'($urandom);
      r[4] = (i >= 6);
      other = r[2];
      route_b = r[5];
      sout = r[6];
      line = r[7];
      ring = r[0];
      lcr = {1'b0, r[1], 6'h03};
      wreg(MODEM_LINE_CONTROL_ADDR, r);
      mlc_m = r & MLC_WRITE_MASK;
      rreg(MODEM_LINE_CONTROL_ADDR, mlc_m);
      probe_pins;
    end
    wreg(MODEM_LINE_CONTROL_ADDR, 8'h00);
    mlc_m = 8'h00;
    other = 1'b0;
    line = 1'b1;
    sout = 1'b1;
    // Odd and even parity, good and bad parity bit, then parity off with a good and then a bad stop bit.
    for (int k = 0; k < 6; k++) begin
      rxd = 8'($urandom);
      lcr = {3'b000, k[0], (k < 4), 3'b011};
      par = ^rxd ^ ~k[0] ^ (k[1] | k[2]);
      stop = (k != 5);
      pexp = (k < 4) && k[1];
      pulse(P_DONE);
      sls_m = {4'h6, ~stop, pexp, 2'b01};
      probe_pins;
      rreg(SERIAL_LINE_STATE_ADDR, sls_m);
      sls_m = 8'h61;
      rreg(SERIAL_LINE_STATE_ADDR, sls_m);
      pulse(P_DRAIN);
      sls_m = 8'h60;
      rreg(SERIAL_LINE_STATE_ADDR, sls_m);
    end
    stop = 1'b1;
    lcr = 8'h03;
    pulse(P_DONE);
    pulse(P_DONE);
    rreg(SERIAL_LINE_STATE_ADDR, 8'h63);
    pulse(P_DRAIN);
    rreg(SERIAL_LINE_STATE_ADDR, 8'h60);
    line = 1'b0;
    repeat (9) pulse(P_TICK);
    rreg(SERIAL_LINE_STATE_ADDR, 8'h60);
    repeat (4) pulse(P_TICK);
    sls_m = 8'h70;
    probe_pins;
    rreg(SERIAL_LINE_STATE_ADDR, 8'h70);
    line = 1'b1;
    sls_m = 8'h60;
    rreg(SERIAL_LINE_STATE_ADDR, 8'h60);
    wreg(MODEM_LINE_CONTROL_ADDR, 8'h08);
    mlc_m = 8'h08;
    probe_pins;
    pulse(P_HWR);
    sls_m = 8'h00;
    pend_m = 1'b0;
    rreg(SERIAL_LINE_STATE_ADDR, 8'h00);
    probe_pins;
    pulse(P_LOAD);
    sls_m = 8'h20;
    pend_m = 1'b1;
    rreg(SERIAL_LINE_STATE_ADDR, 8'h20);
    rreg(SERIAL_LINE_STATE_ADDR, 8'h20);
    probe_pins;
    pulse(P_IDENT);
    pend_m = 1'b0;
    probe_pins;
    pulse(P_SDONE);
    sls_m = 8'h60;
    rreg(SERIAL_LINE_STATE_ADDR, 8'h60);
    conclude;
  end
endmodule // tb_uart_modem_ctrl_line_status
